// file: design/drive_protection_defs.vh
`ifndef DRIVE_PROTECTION_DEFS_VH
`define DRIVE_PROTECTION_DEFS_VH

// Register offsets (byte addresses, one word each)
`define OFS_CTRL 8'h00
`define OFS_LOSS_TIME 8'h04
`define OFS_VOLT_MIN 8'h08
`define OFS_VOLT2_MIN 8'h0c
`define OFS_CURR_MIN 8'h10
`define OFS_BRAKE_DUTY 8'h14
`define OFS_OUT_FUNC 8'h18
`define OFS_STATUS 8'h1c
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24

// Control register fields
`define CTRL_DET_LSB 0
`define CTRL_REACT_LSB 2
`define CTRL_BRAKE_EN_BIT 4
`define CTRL_CHARGE_EN_BIT 5
`define CTRL_SRC_LSB 6

// Reset values
`define RST_DET_SEL 2'h0
`define RST_REACT_SEL 2'h0
`define RST_BRAKE_EN 1'h1
`define RST_CHARGE_EN 1'h1
`define RST_SRC_SEL 2'h0
`define RST_LOSS_TIME 11'h00a
`define RST_BRAKE_DUTY 5'h0a
`define RST_OUT_FUNC 5'h11

// Setting encodings and limits
`define DET_OFF 2'h0
`define DET_HALF 2'h1
`define DET_FULL 2'h2
`define REACT_CONTINUE 2'h0
`define REACT_FREE_RUN 2'h1
`define REACT_DECEL 2'h2
`define SRC_VOLT 2'h0
`define SRC_VOLT2_CURR 2'h1
`define SRC_COMM 2'h2
`define FUNC_SPEED_LOSS 5'h0b
`define LOSS_TIME_MIN 11'h001
`define LOSS_TIME_MAX 11'h4b0
`define BRAKE_DUTY_MAX 5'h1e
`define FUNC_MAX 5'h13

// Interrupt status bits
`define IRQ_LOSS_BIT 0
`define IRQ_BRAKE_BIT 1
`define IRQ_CHARGE_BIT 2

// Timing: base tick 0.1 s, continuous braking limit 15 s, duty window 10 s
// Counts are kept in ticks so no intermediate product overflows 32 bits
`define CLK_PERIOD_NS 40
`define TICK_NS 100000000
`define BRAKE_CONT_TICKS 11'h096
`define DUTY_WINDOW_TICKS 32'h64
`define PERCENT_FULL 100

`endif

// file: design/drive_protection_monitor.v
// Contract
// - Handle speed command loss for analog terminal or communication references.
// - Detect select: 0 off, 1 below half threshold, 2 below full threshold.
// - Combined voltage plus current reference: either below its threshold means loss.
// - Act only after the condition holds for the decision time, 0.1 to 120 s.
// - Reaction: 0 keep frequency, 1 free-run output block, 2 deceleration stop.
// - Relay or second output with function 11 shows the loss state.
// - Brake limit enable: 0 no duty limit, 1 limit to duty level.
// - Brake duty level 0 to 30 percent, default 10, fraction of cycle.
// - Duty level is shown and used only while the limit enable is 1.
// - Continuous braking ends after at most 15 s, drive withdrawn.
// - Duty is braking time as percent of the whole operation cycle.
// - Charging circuit trip enable, default 1; 0 disables the trip.
// - When enabled, trip on unstable power or charging fault during power-up.
`timescale 1ns/1ps
`default_nettype none
`include "drive_protection_defs.vh"

module drive_protection_monitor #(
  parameter ADC_WIDTH = 12,
  parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS,
  parameter DUTY_WINDOW_TICKS = `DUTY_WINDOW_TICKS
) (
  input wire ref_clk,
  input wire arst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  input wire [ADC_WIDTH-1:0] voltage_speed_input,
  input wire [ADC_WIDTH-1:0] voltage_speed_input2,
  input wire [ADC_WIDTH-1:0] current_speed_input,
  input wire comm_ref_lost,
  input wire brake_request,
  input wire precharge_active,
  input wire charge_fault,
  input wire power_unstable,
  output reg speed_loss,
  output reg hold_frequency,
  output reg decel_stop,
  output reg output_block,
  output reg dynamic_braking,
  output reg charge_circuit_trip,
  output reg fault_relay,
  output reg aux_output,
  output wire irq
);

  function below_level;
    input [ADC_WIDTH-1:0] val;
    input [ADC_WIDTH-1:0] thr;
    input [1:0] sel;
    begin
      case (sel)
        `DET_HALF: below_level = val < (thr >> 1);
        `DET_FULL: below_level = val < thr;
        default: below_level = 1'b0;
      endcase
    end
  endfunction

  function shows_loss;
    input [4:0] func;
    begin
      shows_loss = (func == `FUNC_SPEED_LOSS);
    end
  endfunction

  // Settings
  reg [1:0] det_sel_r;
  reg [1:0] react_sel_r;
  reg [1:0] src_sel_r;
  reg brake_en_r;
  reg charge_en_r;
  reg [10:0] loss_time_r;
  reg [ADC_WIDTH-1:0] volt_min_r;
  reg [ADC_WIDTH-1:0] volt2_min_r;
  reg [ADC_WIDTH-1:0] curr_min_r;
  reg [4:0] brake_duty_r;
  reg [4:0] relay_function_select_r;
  reg [4:0] aux_output_function_select_r;
  reg [2:0] irq_status_r;
  reg [2:0] irq_mask_r;

  // Pin synchronisers
  reg [3:0] pin_meta_r;
  reg [3:0] pin_sync_r;
  wire comm_lost_s;
  wire precharge_s;
  wire charge_fault_s;
  wire unstable_s;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {power_unstable, charge_fault, precharge_active, comm_ref_lost};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign comm_lost_s = pin_sync_r[0];
  assign precharge_s = pin_sync_r[1];
  assign charge_fault_s = pin_sync_r[2];
  assign unstable_s = pin_sync_r[3];

  // 0.1 s time base
  reg [31:0] tick_cnt_r;
  reg tick_r;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // Speed command loss condition
  reg loss_cond;

  always @* begin
    case (src_sel_r)
      `SRC_VOLT: loss_cond = below_level(voltage_speed_input, volt_min_r, det_sel_r);
      `SRC_VOLT2_CURR: loss_cond = below_level(voltage_speed_input2, volt2_min_r, det_sel_r) ||
                                   below_level(current_speed_input, curr_min_r, det_sel_r);
      `SRC_COMM: loss_cond = comm_lost_s && (det_sel_r != `DET_OFF);
      default: loss_cond = 1'b0;
    endcase
  end

  wire loss_confirmed;

  hold_timer #(
    .WIDTH(11)
  ) u_loss_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick_r),
    .cond(loss_cond),
    .limit(loss_time_r),
    .done(loss_confirmed)
  );

  // Continuous braking limit
  wire brake_cont_expired;

  hold_timer #(
    .WIDTH(11)
  ) u_brake_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick_r),
    .cond(brake_request),
    .limit(`BRAKE_CONT_TICKS),
    .done(brake_cont_expired)
  );

  // Braking duty over a fixed window
  reg [15:0] win_cnt_r;
  reg [15:0] on_cnt_r;
  wire [31:0] on_scaled;
  wire [31:0] budget;
  wire duty_ok;

  assign on_scaled = on_cnt_r * `PERCENT_FULL;
  assign budget = brake_duty_r * DUTY_WINDOW_TICKS;
  assign duty_ok = on_scaled < budget;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      win_cnt_r <= 16'h0;
      on_cnt_r <= 16'h0;
    end else if (tick_r) begin
      if (win_cnt_r >= DUTY_WINDOW_TICKS - 1) begin
        win_cnt_r <= 16'h0;
        on_cnt_r <= 16'h0;
      end else begin
        win_cnt_r <= win_cnt_r + 16'h1;
        if (dynamic_braking) begin
          on_cnt_r <= on_cnt_r + 16'h1;
        end
      end
    end
  end

  wire brake_limited;
  wire brake_drive_nxt;

  assign brake_limited = brake_en_r && !duty_ok;
  assign brake_drive_nxt = brake_request && !brake_cont_expired && !brake_limited && !output_block;

  // Charging circuit trip, latched until reset by power cycle
  reg charge_trip_r;
  wire charge_event;

  assign charge_event = charge_en_r && precharge_s && (charge_fault_s || unstable_s);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_trip_r <= 1'b0;
    end else if (charge_event) begin
      charge_trip_r <= 1'b1;
    end
  end

  // Event edges for interrupt status
  reg loss_prev_r;
  reg brake_lim_prev_r;
  reg charge_prev_r;
  wire [2:0] irq_set;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      loss_prev_r <= 1'b0;
      brake_lim_prev_r <= 1'b0;
      charge_prev_r <= 1'b0;
    end else begin
      loss_prev_r <= loss_confirmed;
      brake_lim_prev_r <= brake_limited || (brake_request && brake_cont_expired);
      charge_prev_r <= charge_trip_r;
    end
  end

  assign irq_set[`IRQ_LOSS_BIT] = loss_confirmed && !loss_prev_r;
  assign irq_set[`IRQ_BRAKE_BIT] = (brake_limited || (brake_request && brake_cont_expired)) && !brake_lim_prev_r;
  assign irq_set[`IRQ_CHARGE_BIT] = charge_trip_r && !charge_prev_r;
  assign irq = |(irq_status_r & irq_mask_r);

  // Registered outputs
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      speed_loss <= 1'b0;
      hold_frequency <= 1'b0;
      decel_stop <= 1'b0;
      output_block <= 1'b0;
      dynamic_braking <= 1'b0;
      charge_circuit_trip <= 1'b0;
      fault_relay <= 1'b0;
      aux_output <= 1'b0;
    end else begin
      speed_loss <= loss_confirmed;
      hold_frequency <= loss_confirmed && (react_sel_r == `REACT_CONTINUE);
      decel_stop <= loss_confirmed && (react_sel_r == `REACT_DECEL);
      output_block <= charge_trip_r || (loss_confirmed && (react_sel_r == `REACT_FREE_RUN));
      dynamic_braking <= brake_drive_nxt;
      charge_circuit_trip <= charge_trip_r;
      fault_relay <= shows_loss(relay_function_select_r) && loss_confirmed;
      aux_output <= shows_loss(aux_output_function_select_r) && loss_confirmed;
    end
  end

  // Register writes
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      det_sel_r <= `RST_DET_SEL;
      react_sel_r <= `RST_REACT_SEL;
      src_sel_r <= `RST_SRC_SEL;
      brake_en_r <= `RST_BRAKE_EN;
      charge_en_r <= `RST_CHARGE_EN;
      loss_time_r <= `RST_LOSS_TIME;
      volt_min_r <= {ADC_WIDTH{1'b0}};
      volt2_min_r <= {ADC_WIDTH{1'b0}};
      curr_min_r <= {ADC_WIDTH{1'b0}};
      brake_duty_r <= `RST_BRAKE_DUTY;
      relay_function_select_r <= `RST_OUT_FUNC;
      aux_output_function_select_r <= `RST_OUT_FUNC;
      irq_mask_r <= 3'h0;
    end else if (wr_en) begin
      case (addr)
        `OFS_CTRL: begin
          det_sel_r <= (wdata[`CTRL_DET_LSB+1:`CTRL_DET_LSB] > `DET_FULL) ? `DET_OFF :
                       wdata[`CTRL_DET_LSB+1:`CTRL_DET_LSB];
          react_sel_r <= (wdata[`CTRL_REACT_LSB+1:`CTRL_REACT_LSB] > `REACT_DECEL) ? `REACT_CONTINUE :
                         wdata[`CTRL_REACT_LSB+1:`CTRL_REACT_LSB];
          brake_en_r <= wdata[`CTRL_BRAKE_EN_BIT];
          charge_en_r <= wdata[`CTRL_CHARGE_EN_BIT];
          src_sel_r <= (wdata[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB] > `SRC_COMM) ? `SRC_VOLT :
                       wdata[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB];
        end
        `OFS_LOSS_TIME: begin
          if (wdata[10:0] < `LOSS_TIME_MIN || wdata[31:11] != 21'h0) begin
            loss_time_r <= (wdata[31:11] != 21'h0) ? `LOSS_TIME_MAX : `LOSS_TIME_MIN;
          end else if (wdata[10:0] > `LOSS_TIME_MAX) begin
            loss_time_r <= `LOSS_TIME_MAX;
          end else begin
            loss_time_r <= wdata[10:0];
          end
        end
        `OFS_VOLT_MIN: volt_min_r <= wdata[ADC_WIDTH-1:0];
        `OFS_VOLT2_MIN: volt2_min_r <= wdata[ADC_WIDTH-1:0];
        `OFS_CURR_MIN: curr_min_r <= wdata[ADC_WIDTH-1:0];
        `OFS_BRAKE_DUTY: begin
          if (brake_en_r) begin
            brake_duty_r <= (wdata[31:0] > {27'h0, `BRAKE_DUTY_MAX}) ? `BRAKE_DUTY_MAX : wdata[4:0];
          end
        end
        `OFS_OUT_FUNC: begin
          if (wdata[4:0] <= `FUNC_MAX) begin
            relay_function_select_r <= wdata[4:0];
          end
          if (wdata[12:8] <= `FUNC_MAX) begin
            aux_output_function_select_r <= wdata[12:8];
          end
        end
        `OFS_IRQ_MASK: irq_mask_r <= wdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status: a new event wins over the clearing read
  wire status_read;

  assign status_read = rd_en && (addr == `OFS_IRQ_STATUS);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status_r <= 3'h0;
    end else if (status_read) begin
      irq_status_r <= irq_set;
    end else begin
      irq_status_r <= irq_status_r | irq_set;
    end
  end

  // Read data, one cycle after the strobe and only then
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0;
    case (addr)
      `OFS_CTRL: begin
        rd_mux[`CTRL_DET_LSB+1:`CTRL_DET_LSB] = det_sel_r;
        rd_mux[`CTRL_REACT_LSB+1:`CTRL_REACT_LSB] = react_sel_r;
        rd_mux[`CTRL_BRAKE_EN_BIT] = brake_en_r;
        rd_mux[`CTRL_CHARGE_EN_BIT] = charge_en_r;
        rd_mux[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB] = src_sel_r;
      end
      `OFS_LOSS_TIME: rd_mux[10:0] = loss_time_r;
      `OFS_VOLT_MIN: rd_mux[ADC_WIDTH-1:0] = volt_min_r;
      `OFS_VOLT2_MIN: rd_mux[ADC_WIDTH-1:0] = volt2_min_r;
      `OFS_CURR_MIN: rd_mux[ADC_WIDTH-1:0] = curr_min_r;
      `OFS_BRAKE_DUTY: rd_mux[4:0] = brake_en_r ? brake_duty_r : 5'h00;
      `OFS_OUT_FUNC: begin
        rd_mux[4:0] = relay_function_select_r;
        rd_mux[12:8] = aux_output_function_select_r;
      end
      `OFS_STATUS: begin
        rd_mux[0] = loss_cond;
        rd_mux[1] = loss_confirmed;
        rd_mux[2] = dynamic_braking;
        rd_mux[3] = brake_cont_expired;
        rd_mux[4] = brake_limited;
        rd_mux[5] = charge_trip_r;
        rd_mux[6] = output_block;
      end
      `OFS_IRQ_STATUS: rd_mux[2:0] = irq_status_r;
      `OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_r;
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0;
    end else if (rd_en) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule // drive_protection_monitor

`default_nettype wire

// file: design/hold_timer.v
`timescale 1ns/1ps
`default_nettype none

// Counts ticks while cond holds; done once the count reaches limit
module hold_timer #(
  parameter WIDTH = 11
) (
  input wire ref_clk,
  input wire arst_n,
  input wire tick,
  input wire cond,
  input wire [WIDTH-1:0] limit,
  output wire done
);

  reg [WIDTH-1:0] cnt_r;
  reg [WIDTH-1:0] cnt_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    if (!cond) begin
      cnt_nxt = {WIDTH{1'b0}};
    end else if (tick && (cnt_r < limit)) begin
      cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= {WIDTH{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Any break in cond restarts the count from zero
  assign done = cond && (cnt_r >= limit);

endmodule // hold_timer

`default_nettype wire

// file: tb/protection_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module protection_checker #(
  parameter TICK_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic brake_request,
  input wire logic speed_loss,
  input wire logic hold_frequency,
  input wire logic decel_stop,
  input wire logic output_block,
  input wire logic dynamic_braking,
  input wire logic charge_circuit_trip,
  input wire logic fault_relay,
  input wire logic aux_output
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Length of the present unbroken braking run
  logic [15:0] run_r;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      run_r <= 16'h0;
    else
      run_r <= dynamic_braking ? run_r + 16'h1 : 16'h0;
  end
  sequence s_brake_off;
    !brake_request ##1 !dynamic_braking;
  endsequence
  sequence s_trip_held;
    charge_circuit_trip ##1 charge_circuit_trip;
  endsequence
  a_brake_release: assert property (!brake_request |-> s_brake_off)
    else $error("braking kept without request");
  a_brake_cause: assert property (dynamic_braking |-> $past(brake_request))
    else $error("braking without request");
  a_cont_limit: assert property (run_r <= 151 * TICK_CYCLES + 2)
    else $error("continuous braking too long");
  a_block_brake: assert property (output_block [*2] |-> !dynamic_braking)
    else $error("braking during output block");
  a_trip_latch: assert property (charge_circuit_trip |-> s_trip_held)
    else $error("charge trip released");
  a_trip_block: assert property (charge_circuit_trip |-> output_block)
    else $error("charge trip without block");
  a_hold_loss: assert property (hold_frequency |-> speed_loss && !decel_stop)
    else $error("hold without loss");
  a_decel_loss: assert property (decel_stop |-> speed_loss && !output_block)
    else $error("decel without loss");
  a_relay_loss: assert property (fault_relay || aux_output |-> speed_loss)
    else $error("relay shows loss wrongly");
endmodule // protection_checker
bind drive_protection_monitor protection_checker #(.TICK_CYCLES(TICK_CYCLES)) protection_checker_i (
  .ref_clk, .arst_n, .brake_request, .speed_loss, .hold_frequency, .decel_stop,
  .output_block, .dynamic_braking, .charge_circuit_trip, .fault_relay, .aux_output);
`default_nettype wire

// file: tb/speed_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
module speed_ref_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [2:0] cable_ok,
  input wire logic comm_ok,
  input wire logic [11:0] lost_level,
  output logic [11:0] volt_out,
  output logic [11:0] volt2_out,
  output logic [11:0] curr_out,
  output logic comm_lost
);
  localparam logic [11:0] NOMINAL = 12'h800;
  // A broken cable reads the low level the bench picks
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_out <= NOMINAL;
      volt2_out <= NOMINAL;
      curr_out <= NOMINAL;
      comm_lost <= 1'b0;
    end else begin
      volt_out <= cable_ok[0] ? NOMINAL : lost_level;
      volt2_out <= cable_ok[1] ? NOMINAL : lost_level;
      curr_out <= cable_ok[2] ? NOMINAL : lost_level;
      comm_lost <= !comm_ok;
    end
  end
endmodule // speed_ref_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TC = 4;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic [2:0] cable_ok = 3'h7;
  logic comm_ok = 1'b1;
  logic [11:0] lost_level = 12'h0c0;
  logic brake_request = 1'b0;
  logic precharge_active = 1'b0;
  logic charge_fault = 1'b0;
  logic power_unstable = 1'b0;
  logic [11:0] v1, v2, ci;
  logic comm_lost;
  logic speed_loss, hold_frequency, decel_stop, output_block, dynamic_braking;
  logic charge_circuit_trip, fault_relay, aux_output, irq;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  int on;

  drive_protection_monitor #(.ADC_WIDTH(12), .TICK_CYCLES(TC), .DUTY_WINDOW_TICKS(10)) drive_protection_monitor_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .voltage_speed_input(v1), .voltage_speed_input2(v2),
    .current_speed_input(ci), .comm_ref_lost(comm_lost), .brake_request(brake_request),
    .precharge_active(precharge_active), .charge_fault(charge_fault),
    .power_unstable(power_unstable), .speed_loss(speed_loss), .hold_frequency(hold_frequency),
    .decel_stop(decel_stop), .output_block(output_block), .dynamic_braking(dynamic_braking),
    .charge_circuit_trip(charge_circuit_trip), .fault_relay(fault_relay),
    .aux_output(aux_output), .irq(irq));
  speed_ref_model speed_ref_model_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .cable_ok(cable_ok), .comm_ok(comm_ok),
    .lost_level(lost_level), .volt_out(v1), .volt2_out(v2), .curr_out(ci), .comm_lost(comm_lost));

  initial begin
    forever #20 ref_clk = !ref_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    chk(rdata, exp);
  endtask

  task automatic wt(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    chk(k < lim, 1'b1);
  endtask

  task automatic give_verdict;
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    cyc(20000);
    error_cnt++;
    $display("Error %0t: watchdog expired", $time);
    give_verdict;
  end

  initial begin
    cyc(16);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd_chk(8'h00, 32'h30);
    rd_chk(8'h04, 32'h0a);
    rd_chk(8'h14, 32'h0a);
    rd_chk(8'h18, 32'h1111);
    rd_chk(8'h28, 32'h0);
    wr(8'h14, 32'h28);
    rd_chk(8'h14, 32'h1e);
    wr(8'h00, 32'h20);
    rd_chk(8'h14, 32'h0);
    $display("Test settings done");
    wr(8'h08, 32'h100);
    wr(8'h0c, 32'h100);
    wr(8'h10, 32'h100);
    wr(8'h04, 32'h3);
    wr(8'h18, 32'h0b0b);
    wr(8'h24, 32'h1);
    wr(8'h00, 32'h31);
    cable_ok <= 3'b110;
    cyc(30);
    chk(speed_loss, 1'b0);
    lost_level <= 12'h07f;
    wt(speed_loss, 1'b1, 40, n);
    chk(n >= 8 && n <= 20, 1'b1);
    chk({hold_frequency, fault_relay, aux_output, irq}, 4'hf);
    cable_ok <= 3'b111;
    lost_level <= 12'h0c0;
    wt(speed_loss, 1'b0, 10, n);
    rd_chk(8'h20, 32'h1);
    chk(irq, 1'b0);
    $display("Test half threshold done");
    for (int r = 0; r < 3; r++) begin
      wr(8'h00, 32'h72 | (r << 2));
      cable_ok <= r[0] ? 3'b011 : 3'b101;
      wt(speed_loss, 1'b1, 40, n);
      chk({hold_frequency, output_block, decel_stop}, 3'b100 >> r);
      cable_ok <= 3'b111;
      wt(speed_loss, 1'b0, 10, n);
    end
    wr(8'h00, 32'hb2);
    comm_ok <= 1'b0;
    wt(speed_loss, 1'b1, 40, n);
    comm_ok <= 1'b1;
    wt(speed_loss, 1'b0, 10, n);
    $display("Test reactions done");
    wr(8'h00, 32'h20);
    brake_request <= 1'b1;
    cyc(2);
    chk(dynamic_braking, 1'b1);
    wt(dynamic_braking, 1'b0, 700, n);
    chk(n >= 590 && n <= 610, 1'b1);
    brake_request <= 1'b0;
    wr(8'h00, 32'h30);
    wr(8'h14, 32'h0a);
    brake_request <= 1'b1;
    on = 0;
    repeat (80) begin
      @(posedge ref_clk);
      on += dynamic_braking;
    end
    chk(on >= 3 && on <= 12, 1'b1);
    brake_request <= 1'b0;
    $display("Test braking done");
    wr(8'h00, 32'h10);
    precharge_active <= 1'b1;
    charge_fault <= 1'b1;
    cyc(10);
    chk(charge_circuit_trip, 1'b0);
    charge_fault <= 1'b0;
    // Let the stale fault leave the synchroniser before enabling the trip
    cyc(3);
    wr(8'h00, 32'h30);
    power_unstable <= 1'b1;
    wt(charge_circuit_trip, 1'b1, 10, n);
    power_unstable <= 1'b0;
    cyc(5);
    chk({charge_circuit_trip, output_block}, 2'b11);
    arst_n <= 1'b0;
    cyc(2);
    chk(charge_circuit_trip, 1'b0);
    arst_n <= 1'b1;
    charge_fault <= 1'b1;
    wt(charge_circuit_trip, 1'b1, 10, n);
    $display("Test charge trip done");
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
